// ### core/tmrc_map.svh
`ifndef TMRC_MAP_SVH
`define TMRC_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets on the avalon slave
// ----------------------------------------------------------------
`define TMRC_OFS_CTRL 5'h00
`define TMRC_OFS_CNT_LO 5'h04
`define TMRC_OFS_CNT_HI 5'h08
`define TMRC_OFS_CMP_LO 5'h0c
`define TMRC_OFS_CMP_HI 5'h10
`define TMRC_OFS_STAT 5'h14
`define TMRC_OFS_MASK 5'h18
`define TMRC_OFS_AUX 5'h1c

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define TMRC_STAT_OVF 0
`define TMRC_STAT_SEV 1
`define TMRC_CTRL_RST 8'h00
`define TMRC_AUX_RST 4'h0
`define TMRC_IRQ_RST 2'h0
`define TMRC_CNT_RST 16'h0000
`define TMRC_CMP_RST 16'hffff
`define TMRC_CNT_MAX 16'hffff

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define TMRC_FOSC_DIV 3'h4
`define TMRC_DIV_LAST 2'h3

`endif

// ### core/tmrc_pkg.sv
package tmrc_pkg;

	// ----------------------------------------------------------------
	// control register, bit 7 first
	// ----------------------------------------------------------------
	typedef struct packed {
		logic gate_polarity;
		logic gate_enable;
		logic [1:0] prescale_select;
		logic lp_osc_enable;
		logic sync_disable;
		logic clock_source_select;
		logic timer_on;
	} tmrc_ctrl_type;

	// ----------------------------------------------------------------
	// auxiliary control: oscillator, capture/compare and comparator side
	// ----------------------------------------------------------------
	typedef struct packed {
		logic lp_mode_ok;
		logic gate_source_select;
		logic comp_sync;
		logic sev_enable;
	} tmrc_aux_type;

endpackage

// ### core/tmrc_top.sv
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`include "tmrc_map.svh"
`timescale 1ns/10ps
`default_nettype none

module tmrc_top
	import tmrc_pkg::*;
(
	input wire logic clk_i, // system clock, fosc
	input wire logic arst_n_i, // async reset, active low
	input wire logic ce_i, // clock enable, freezes all state when low
	input wire logic [4:0] avs_address_i, // byte address
	input wire logic avs_read_i, // read request
	input wire logic avs_write_i, // write request
	input wire logic [31:0] avs_writedata_i, // write data
	input wire logic [3:0] avs_byteenable_i, // byte lanes
	output logic [31:0] avs_readdata_o, // read data
	output logic avs_waitrequest_o, // stall
	input wire logic external_clock_pin_i, // external count clock pin
	input wire logic gate_pin_i, // gate pin level
	input wire logic comparator_two_output_i, // comparator level
	output logic [15:0] count_o, // count to the capture/compare unit
	output logic special_event_o, // one-cycle special event pulse
	output logic lp_osc_en_o, // low-power oscillator enable
	output logic irq_o // level interrupt
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [2:0] presc_last(input logic [1:0] sel);
		case (sel)
			2'h3: presc_last = 3'h7;
			2'h2: presc_last = 3'h3;
			2'h1: presc_last = 3'h1;
			default: presc_last = 3'h0;
		endcase
	endfunction

	function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
		hit = (addr[4:2] == ofs[4:2]);
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	tmrc_ctrl_type ctrl_reg;
	tmrc_aux_type aux_reg;
	logic [15:0] cnt_reg;
	logic [15:0] cmp_reg;
	logic [1:0] stat_reg;
	logic [1:0] stat_next;
	logic [1:0] mask_reg;
	logic [1:0] div_reg;
	logic [2:0] presc_reg;
	logic wait_reg;
	logic [31:0] rdata_reg;
	logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
	logic gate_s1_reg, gate_s2_reg;
	logic comp_s1_reg, comp_s2_reg;
	logic comp_tmr_reg;
	logic ext_pend_reg;
	logic match_prev_reg;
	logic sev_reg;
	logic lp_reg;
	logic irq_reg;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// a write lands on the edge where waitrequest is sampled low
	logic wr_go;
	logic lane0;
	logic lane1;
	logic wr_ctrl, wr_lo, wr_hi, wr_cmp_lo, wr_cmp_hi, wr_stat, wr_mask, wr_aux;
	logic cnt_wr;

	assign wr_go = avs_write_i && !wait_reg;
	assign lane0 = avs_byteenable_i[0];
	assign lane1 = avs_byteenable_i[1];
	assign wr_ctrl = wr_go && lane0 && hit(avs_address_i, `TMRC_OFS_CTRL);
	assign wr_lo = wr_go && lane0 && hit(avs_address_i, `TMRC_OFS_CNT_LO);
	assign wr_hi = wr_go && lane0 && hit(avs_address_i, `TMRC_OFS_CNT_HI);
	assign wr_cmp_lo = wr_go && lane0 && hit(avs_address_i, `TMRC_OFS_CMP_LO);
	assign wr_cmp_hi = wr_go && lane0 && hit(avs_address_i, `TMRC_OFS_CMP_HI);
	assign wr_stat = wr_go && lane0 && hit(avs_address_i, `TMRC_OFS_STAT);
	assign wr_mask = wr_go && lane0 && hit(avs_address_i, `TMRC_OFS_MASK);
	assign wr_aux = wr_go && lane0 && hit(avs_address_i, `TMRC_OFS_AUX);
	assign cnt_wr = wr_lo || wr_hi;

	// waitrequest drops for exactly one cycle per request
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wait_reg <= 1'b1;
		end else if (ce_i) begin
			wait_reg <= !((avs_read_i || avs_write_i) && wait_reg);
		end
	end

	// read data captured one cycle early so it stands when waitrequest is low
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_reg <= 32'h0000_0000;
		end else if (ce_i && avs_read_i && wait_reg) begin
			rdata_reg <= 32'h0000_0000;
			unique case (avs_address_i[4:2])
				3'h0: rdata_reg[7:0] <= ctrl_reg;
				3'h1: rdata_reg[7:0] <= cnt_reg[7:0];
				3'h2: rdata_reg[7:0] <= cnt_reg[15:8];
				3'h3: rdata_reg[7:0] <= cmp_reg[7:0];
				3'h4: rdata_reg[7:0] <= cmp_reg[15:8];
				3'h5: rdata_reg[1:0] <= stat_reg;
				3'h6: rdata_reg[1:0] <= mask_reg;
				3'h7: rdata_reg[3:0] <= aux_reg;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_reg <= `TMRC_CTRL_RST;
		end else if (ce_i && wr_ctrl) begin
			ctrl_reg <= avs_writedata_i[7:0];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			aux_reg <= `TMRC_AUX_RST;
			cmp_reg <= `TMRC_CMP_RST;
			mask_reg <= `TMRC_IRQ_RST;
		end else if (ce_i) begin
			if (wr_aux) begin
				aux_reg <= avs_writedata_i[3:0];
			end
			if (wr_cmp_lo) begin
				cmp_reg[7:0] <= avs_writedata_i[7:0];
			end
			if (wr_cmp_hi) begin
				cmp_reg[15:8] <= avs_writedata_i[7:0];
			end
			if (wr_mask) begin
				mask_reg <= avs_writedata_i[1:0];
			end
		end
	end

	// oscillator only runs where the system clock mode permits sharing it
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			lp_reg <= 1'b0;
		end else if (ce_i) begin
			lp_reg <= ctrl_reg.lp_osc_enable && aux_reg.lp_mode_ok;
		end
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_s3_reg <= 1'b0;
			gate_s1_reg <= 1'b0;
			gate_s2_reg <= 1'b0;
			comp_s1_reg <= 1'b0;
			comp_s2_reg <= 1'b0;
		end else if (ce_i) begin
			ext_s1_reg <= external_clock_pin_i;
			ext_s2_reg <= ext_s1_reg;
			ext_s3_reg <= ext_s2_reg;
			gate_s1_reg <= gate_pin_i;
			gate_s2_reg <= gate_s1_reg;
			comp_s1_reg <= comparator_two_output_i;
			comp_s2_reg <= comp_s1_reg;
		end
	end

	// ----------------------------------------------------------------
	// clock source
	// ----------------------------------------------------------------
	logic ext_rise;
	logic phase_end;
	logic src_tick;

	assign ext_rise = ext_s2_reg && !ext_s3_reg;
	assign phase_end = (div_reg == `TMRC_DIV_LAST);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			div_reg <= 2'h0;
		end else if (ce_i) begin
			div_reg <= div_reg + 2'h1;
		end
	end

	// synchronised mode holds an edge until the next fosc/4 phase
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ext_pend_reg <= 1'b0;
		end else if (ce_i) begin
			if (phase_end) begin
				ext_pend_reg <= 1'b0;
			end else if (ext_rise) begin
				ext_pend_reg <= 1'b1;
			end
		end
	end

	always_comb begin
		if (!ctrl_reg.clock_source_select) begin
			src_tick = phase_end;
		end else if (ctrl_reg.sync_disable) begin
			src_tick = ext_rise;
		end else begin
			src_tick = phase_end && (ext_pend_reg || ext_rise);
		end
	end

	// ----------------------------------------------------------------
	// gate
	// ----------------------------------------------------------------
	logic comp_eff;
	logic gate_lvl;
	logic gate_ok;

	// resampling on the timer tick keeps a comparator edge from splitting an increment
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			comp_tmr_reg <= 1'b0;
		end else if (ce_i && src_tick) begin
			comp_tmr_reg <= comp_s2_reg;
		end
	end

	assign comp_eff = aux_reg.comp_sync ? comp_tmr_reg : comp_s2_reg;
	assign gate_lvl = aux_reg.gate_source_select ? comp_eff : gate_s2_reg;
	assign gate_ok = !ctrl_reg.gate_enable || (gate_lvl == ctrl_reg.gate_polarity);

	// ----------------------------------------------------------------
	// prescaler and count
	// ----------------------------------------------------------------
	logic cnt_en;
	logic inc;
	logic match;
	logic sev;
	logic ovf_evt;

	assign cnt_en = ctrl_reg.timer_on && gate_ok && src_tick;
	assign inc = cnt_en && (presc_reg == presc_last(ctrl_reg.prescale_select));
	assign match = aux_reg.sev_enable && (cnt_reg == cmp_reg);
	assign sev = match && !match_prev_reg;
	assign ovf_evt = inc && !sev && !cnt_wr && (cnt_reg == `TMRC_CNT_MAX);

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			presc_reg <= 3'h0;
		end else if (ce_i) begin
			if (cnt_wr || inc) begin
				presc_reg <= 3'h0;
			end else if (cnt_en) begin
				presc_reg <= presc_reg + 3'h1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_reg <= `TMRC_CNT_RST;
		end else if (ce_i) begin
			if (cnt_wr) begin
				if (wr_lo) begin
					cnt_reg[7:0] <= avs_writedata_i[7:0];
				end
				if (wr_hi) begin
					cnt_reg[15:8] <= avs_writedata_i[7:0];
				end
			end else if (sev) begin
				cnt_reg <= `TMRC_CNT_RST;
			end else if (inc) begin
				cnt_reg <= cnt_reg + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			match_prev_reg <= 1'b0;
			sev_reg <= 1'b0;
		end else if (ce_i) begin
			match_prev_reg <= match;
			sev_reg <= sev;
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	// a set in the same cycle as a write-one clear survives
	always_comb begin
		stat_next = stat_reg;
		if (wr_stat) begin
			stat_next = stat_reg & ~avs_writedata_i[1:0];
		end
		if (ovf_evt) begin
			stat_next[`TMRC_STAT_OVF] = 1'b1;
		end
		if (sev) begin
			stat_next[`TMRC_STAT_SEV] = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			stat_reg <= `TMRC_IRQ_RST;
			irq_reg <= 1'b0;
		end else if (ce_i) begin
			stat_reg <= stat_next;
			irq_reg <= |(stat_next & mask_reg);
		end
	end

	assign avs_readdata_o = rdata_reg;
	assign avs_waitrequest_o = wait_reg;
	assign count_o = cnt_reg;
	assign special_event_o = sev_reg;
	assign lp_osc_en_o = lp_reg;
	assign irq_o = irq_reg;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!arst_n_i || !ce_i);

	AST_SEV_CLEARS: assert property (
		sev && !cnt_wr ##1 ce_i |-> cnt_reg == 16'h0000 && special_event_o)
		else $error("special event did not clear the count");

	AST_SEV_NO_OVF: assert property (
		sev && !wr_stat && !cnt_wr |=> stat_reg[0] == $past(stat_reg[0]))
		else $error("special event clear raised the overflow flag");

	AST_PERIOD_MATCH: assert property (
		sev |-> aux_reg.sev_enable && cnt_reg == cmp_reg && !$past(match))
		else $error("special event fired without a compare match");

	AST_WRITE_WINS: assert property (
		wr_lo && sev |=> cnt_reg[7:0] == $past(avs_writedata_i[7:0]))
		else $error("count write lost to special event");

	AST_CTRL_WRITE: assert property (
		wr_ctrl |=> ctrl_reg == $past(avs_writedata_i[7:0]))
		else $error("control register write not stored");

	AST_GATE_HOLD: assert property (
		ctrl_reg.gate_enable && gate_lvl != ctrl_reg.gate_polarity && !cnt_wr && !sev
		|=> cnt_reg == $past(cnt_reg))
		else $error("count moved while gate blocked it");

	AST_OFF_HOLD: assert property (
		!ctrl_reg.timer_on && !cnt_wr && !sev |=> $stable(cnt_reg))
		else $error("count moved while timer off");

	// checked on the divider itself so a switch of clock source cannot fake a failure
	AST_FOSC_DIV4: assert property (
		phase_end |=> !phase_end [*3] ##1 phase_end)
		else $error("internal tick not fosc over four");

	AST_INT_TICK: assert property (
		!ctrl_reg.clock_source_select |-> src_tick == phase_end)
		else $error("internal clock selected but tick not from divider");

	AST_SYNC_PHASE: assert property (
		ctrl_reg.clock_source_select && !ctrl_reg.sync_disable && src_tick |-> div_reg == 2'h3)
		else $error("synchronised external tick off phase");

endmodule

`default_nettype wire

// ### test/tmrc_far_model.sv
`timescale 1ns/10ps
`default_nettype none

module tmrc_far_model (
	input wire logic clk_i, // system clock
	output logic ext_clk_o, // external count clock pin
	output logic gate_o, // gate pin level
	output logic cmp_o // comparator output level
);
	initial begin
		ext_clk_o = 1'b0;
		gate_o = 1'b0;
		cmp_o = 1'b0;
	end

	// --------
	// gate and comparator levels
	// --------
	task automatic levels(input logic g, input logic c);
		gate_o <= g;
		cmp_o <= c;
	endtask

	// --------
	// count clock bursts
	// --------
	// the pin rests low between bursts, so n pulses give exactly n rising edges
	task automatic burst(input int n, input int half);
		repeat (n) begin
			repeat (half) @(posedge clk_i);
			ext_clk_o <= 1'b1;
			repeat (half) @(posedge clk_i);
			ext_clk_o <= 1'b0;
		end
	endtask
endmodule

`default_nettype wire

// ### test/tmrc_tb_top.sv
`include "tmrc_map.svh"
`timescale 1ns/10ps
`default_nettype none

module tmrc_tb_top;
	logic clk;
	logic arst_n;
	logic av_rd;
	logic av_wr;
	logic [4:0] av_a;
	logic [31:0] av_wd;
	logic [31:0] av_rdata;
	logic av_wait;
	logic ext_clk;
	logic gate;
	logic cmp;
	logic [15:0] cnt;
	logic sev;
	logic lp;
	logic irq;
	logic [31:0] q;
	logic [15:0] c16;
	logic [15:0] keep;
	logic [15:0] top;
	logic [7:0] v;
	logic [7:0] c8;
	int k;
	int t;
	int errors = 0;
	int compares = 0;
	int cyc = 0;

	tmrc_top dut (
		.clk_i(clk),
		.arst_n_i(arst_n),
		.ce_i(1'b1),
		.avs_address_i(av_a),
		.avs_read_i(av_rd),
		.avs_write_i(av_wr),
		.avs_writedata_i(av_wd),
		.avs_byteenable_i(4'hf),
		.avs_readdata_o(av_rdata),
		.avs_waitrequest_o(av_wait),
		.external_clock_pin_i(ext_clk),
		.gate_pin_i(gate),
		.comparator_two_output_i(cmp),
		.count_o(cnt),
		.special_event_o(sev),
		.lp_osc_en_o(lp),
		.irq_o(irq)
	);

	tmrc_far_model far (
		.clk_i(clk),
		.ext_clk_o(ext_clk),
		.gate_o(gate),
		.cmp_o(cmp)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			errors++;
			conclude();
		end
	end

	// --------
	// helpers
	// --------
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic done(input string n);
		$display("test %s finished", n);
	endtask

	// one request, held until waitrequest is seen low, then one idle edge
	task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
		av_a <= a;
		av_wd <= {24'h0, d};
		av_wr <= w;
		av_rd <= ~w;
		@(posedge clk);
		while (av_wait !== 1'b0) @(posedge clk);
		q = av_rdata;
		av_wr <= 1'b0;
		av_rd <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd_cnt();
		bus(1'b0, `TMRC_OFS_CNT_LO, 8'h00);
		c16[7:0] = q[7:0];
		bus(1'b0, `TMRC_OFS_CNT_HI, 8'h00);
		c16[15:8] = q[7:0];
	endtask

	// timer stopped while count and status are cleared, then ctl written
	task automatic setup(input logic [7:0] ctl, input logic [3:0] aux);
		bus(1'b1, `TMRC_OFS_CTRL, 8'h00);
		bus(1'b1, `TMRC_OFS_AUX, {4'h0, aux});
		bus(1'b1, `TMRC_OFS_CNT_LO, 8'h00);
		bus(1'b1, `TMRC_OFS_CNT_HI, 8'h00);
		bus(1'b1, `TMRC_OFS_STAT, 8'h03);
		bus(1'b1, `TMRC_OFS_CTRL, ctl);
	endtask

	task automatic stop_rd();
		bus(1'b1, `TMRC_OFS_CTRL, 8'h00);
		rd_cnt();
	endtask

	task automatic conclude();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// --------
	// main sequence
	// --------
	initial begin
		arst_n = 1'b0;
		av_rd = 1'b0;
		av_wr = 1'b0;
		av_a = 5'h00;
		av_wd = 32'h0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		void'($urandom(32'h723b5969));
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, 5'(i * 4), 8'h00);
			chk("reset_value", (i == 3 || i == 4) ? 32'hff : 32'h0, q);
		end
		chk("irq_reset", 32'h0, irq);
		done("reset");
		repeat (8) begin
			v = 8'($urandom);
			bus(1'b1, `TMRC_OFS_CTRL, v);
			bus(1'b0, `TMRC_OFS_CTRL, 8'h00);
			chk("ctrl_rw", v, q);
		end
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, `TMRC_OFS_CTRL, {4'h0, i[0], 3'h0});
			bus(1'b1, `TMRC_OFS_AUX, {4'h0, i[1], 3'h0});
			repeat (2) @(posedge clk);
			chk("lp_osc", i == 3, lp);
		end
		done("control");
		for (int p = 0; p < 4; p++) begin
			k = 3 + $urandom % 5;
			setup({2'b00, p[1:0], 4'h1}, 4'h0);
			repeat (4 * (1 << p) * k) @(posedge clk);
			stop_rd();
			chk("prescale_low", 1, c16 + 1 >= k);
			chk("prescale_high", 1, c16 <= k + 1);
			repeat (20) @(posedge clk);
			keep = c16;
			rd_cnt();
			chk("count_hold", keep, c16);
		end
		done("prescale");
		// comparator resampling stays on whenever it may gate the count
		for (int i = 0; i < 16; i++) begin
			far.levels(i[2] ? ~i[1] : i[1], i[2] ? i[1] : ~i[1]);
			setup({i[0], i[3], 6'h01}, {1'b0, i[2], 2'b10});
			repeat (40) @(posedge clk);
			stop_rd();
			chk("gate", !i[3] || i[1] == i[0], c16 != 0);
		end
		done("gate");
		for (int s = 0; s < 2; s++) begin
			k = 2 + $urandom % 6;
			setup({5'h00, s[0], 2'b11}, 4'h0);
			far.burst(k, 4 + 4 * s);
			repeat (16) @(posedge clk);
			stop_rd();
			chk("ext_count", k, c16);
		end
		done("external");
		c8 = 8'(3 + $urandom % 8);
		bus(1'b1, `TMRC_OFS_CMP_LO, c8);
		bus(1'b1, `TMRC_OFS_CMP_HI, 8'h00);
		bus(1'b1, `TMRC_OFS_MASK, 8'h01);
		setup(8'h01, 4'h1);
		for (int n = 0; n < 2; n++) begin
			top = 16'h0;
			t = 0;
			while (sev !== 1'b1 && t < 200) begin
				if (cnt > top)
					top = cnt;
				t++;
				@(posedge clk);
			end
			chk("event_clear", 32'h0, cnt);
			chk("event_pulse", 32'h1, sev);
			@(posedge clk);
			chk("event_single", 32'h0, sev);
		end
		chk("period", c8, top);
		bus(1'b1, `TMRC_OFS_CTRL, 8'h00);
		bus(1'b0, `TMRC_OFS_STAT, 8'h00);
		chk("event_status", 32'h2, q);
		chk("irq_masked", 32'h0, irq);
		bus(1'b1, `TMRC_OFS_MASK, 8'h02);
		// the new mask reaches the interrupt output one edge after the write lands
		@(posedge clk);
		chk("irq_set", 32'h1, irq);
		bus(1'b1, `TMRC_OFS_STAT, 8'h02);
		chk("irq_clear", 32'h0, irq);
		done("special_event");
		setup(8'h00, 4'h0);
		bus(1'b1, `TMRC_OFS_CNT_LO, 8'hfc);
		bus(1'b1, `TMRC_OFS_CNT_HI, 8'hff);
		bus(1'b1, `TMRC_OFS_CTRL, 8'h01);
		repeat (40) @(posedge clk);
		bus(1'b1, `TMRC_OFS_CTRL, 8'h00);
		bus(1'b0, `TMRC_OFS_STAT, 8'h00);
		chk("overflow_status", 32'h1, q);
		chk("irq_other_masked", 32'h0, irq);
		done("overflow");
		conclude();
	end
endmodule

`default_nettype wire
